// ### common/pll_lock_pkg.sv
// Package: register map, reset values and state types of the PLL lock qualifier
package pll_lock_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register bus geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int CNT_W = 16;

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_LOCK_COUNT = 8'h04;
	localparam logic [7:0] OFS_LOCK_WINDOW = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

	// Control bit positions
	localparam int CTRL_MAIN_IRQ_EN = 0;
	localparam int CTRL_FABRIC_OUT_EN = 1;
	localparam int CTRL_REF_MONITOR = 2;

	// Status bit positions
	localparam int STAT_MAIN_LOCK = 0;
	localparam int STAT_REF_LOCK = 1;
	localparam int STAT_CLK_SWITCH = 2;
	localparam int STAT_RAW_LOCK = 3;
	localparam int STAT_IN_WINDOW = 4;

	// Interrupt event bit positions
	localparam int EV_MAIN_RISE = 0;
	localparam int EV_MAIN_FALL = 1;
	localparam int EV_REF_RISE = 2;
	localparam int EV_REF_FALL = 3;
	localparam int EV_W = 4;

	// Values after reset
	localparam logic [2:0] RST_CTRL = 3'h0;
	localparam logic [CNT_W-1:0] RST_LOCK_COUNT = 16'h0020;
	localparam logic [CNT_W-1:0] RST_LOCK_WINDOW = 16'h1f40;
	localparam logic [EV_W-1:0] RST_IRQ = 4'h0;
	localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// State carriers
	typedef struct packed {
		logic meta;
		logic level;
		logic prev;
	} sync_state_s;

	typedef struct packed {
		logic [2:0] ctrl;
		logic [CNT_W-1:0] lock_count;
		logic [CNT_W-1:0] lock_window;
		logic [EV_W-1:0] irq_status;
		logic [EV_W-1:0] irq_mask;
		logic [CNT_W-1:0] cnt;
		logic lock;
		logic fabric_lock;
		logic clk_switch;
		logic irq;
		logic [DATA_W-1:0] rdata;
	} qual_state_s;

endpackage : pll_lock_pkg

// ### hw/lock_edge_sync.sv
// Two-flop synchroniser for a lock pin with rise and fall pulses
`timescale 1ns/100ps

module lock_edge_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Asynchronous pin
	input wire logic pin,
	// Synchronised level and edge pulses
	output logic level,
	output logic rise,
	output logic fall
);

	pll_lock_pkg::sync_state_s st;
	pll_lock_pkg::sync_state_s next_st;

	always_comb begin
		next_st = st;
		next_st.meta = pin;
		next_st.level = st.meta;
		next_st.prev = st.level;
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign level = st.level;
	assign rise = st.level & ~st.prev;
	assign fall = ~st.level & st.prev;

endmodule : lock_edge_sync

// ### hw/pll_lock_qualifier.sv
// Lock qualification, lock monitoring and interrupts for the main and reference PLLs
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps

// Functional notes
// - Lock indication waits a programmable count of sys_clk cycles, default 32.
// - Lock is declared only while phase error stays inside the ppm window, default 8000.
// - With its enable set, every rise and fall of main lock raises an interrupt.
// - When enabled, the main lock indication is driven out to fabric logic.
// - With monitoring selected, rise and fall of reference PLL lock raise interrupts.
// - Clock configuration switch happens only once both locks are stable.
module pll_lock_qualifier (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// Register port
	input wire logic [pll_lock_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [pll_lock_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [pll_lock_pkg::DATA_W-1:0] reg_rdata,
	// Main PLL
	input wire logic main_pll_raw_lock,
	input wire logic [pll_lock_pkg::CNT_W-1:0] main_pll_phase_err_ppm,
	// Fabric reference PLL
	input wire logic fabric_ref_pll_lock_in,
	// Outputs
	output logic main_pll_lock,
	output logic main_pll_lock_fabric,
	output logic clk_cfg_switch,
	output logic irq
);

	pll_lock_pkg::qual_state_s st;
	pll_lock_pkg::qual_state_s next_st;

	logic raw_lock;
	logic ref_lock;
	logic ref_rise;
	logic ref_fall;
	logic in_window;
	logic qual;
	logic [pll_lock_pkg::EV_W-1:0] ev_set;
	logic [pll_lock_pkg::EV_W-1:0] ev_clr;
	logic [pll_lock_pkg::CNT_W-1:0] cnt_inc;

	////////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	lock_edge_sync u_raw_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pin(main_pll_raw_lock),
		.level(raw_lock),
		.rise(),
		.fall()
	);

	lock_edge_sync u_ref_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.pin(fabric_ref_pll_lock_in),
		.level(ref_lock),
		.rise(ref_rise),
		.fall(ref_fall)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Read data selection
	function automatic logic [pll_lock_pkg::DATA_W-1:0] read_mux(
		input logic [pll_lock_pkg::ADDR_W-1:0] a,
		input pll_lock_pkg::qual_state_s s,
		input logic rl,
		input logic fl,
		input logic iw
	);
		logic [pll_lock_pkg::DATA_W-1:0] r;
		r = '0;
		if (a == pll_lock_pkg::OFS_CTRL) begin
			r[2:0] = s.ctrl;
		end else if (a == pll_lock_pkg::OFS_LOCK_COUNT) begin
			r[pll_lock_pkg::CNT_W-1:0] = s.lock_count;
		end else if (a == pll_lock_pkg::OFS_LOCK_WINDOW) begin
			r[pll_lock_pkg::CNT_W-1:0] = s.lock_window;
		end else if (a == pll_lock_pkg::OFS_STATUS) begin
			r[pll_lock_pkg::STAT_MAIN_LOCK] = s.lock;
			r[pll_lock_pkg::STAT_REF_LOCK] = fl;
			r[pll_lock_pkg::STAT_CLK_SWITCH] = s.clk_switch;
			r[pll_lock_pkg::STAT_RAW_LOCK] = rl;
			r[pll_lock_pkg::STAT_IN_WINDOW] = iw;
		end else if (a == pll_lock_pkg::OFS_IRQ_STATUS) begin
			r[pll_lock_pkg::EV_W-1:0] = s.irq_status;
		end else if (a == pll_lock_pkg::OFS_IRQ_MASK) begin
			r[pll_lock_pkg::EV_W-1:0] = s.irq_mask;
		end
		return r;
	endfunction : read_mux

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	assign in_window = main_pll_phase_err_ppm <= st.lock_window;
	assign qual = raw_lock & in_window;
	assign cnt_inc = st.cnt + 16'h0001;

	always_comb begin
		next_st = st;
		ev_set = '0;
		ev_clr = '0;
		// Register writes
		if (reg_wr) begin
			if (reg_addr == pll_lock_pkg::OFS_CTRL) begin
				next_st.ctrl = reg_wdata[2:0];
			end else if (reg_addr == pll_lock_pkg::OFS_LOCK_COUNT) begin
				next_st.lock_count = reg_wdata[pll_lock_pkg::CNT_W-1:0];
			end else if (reg_addr == pll_lock_pkg::OFS_LOCK_WINDOW) begin
				next_st.lock_window = reg_wdata[pll_lock_pkg::CNT_W-1:0];
			end else if (reg_addr == pll_lock_pkg::OFS_IRQ_STATUS) begin
				ev_clr = reg_wdata[pll_lock_pkg::EV_W-1:0];
			end else if (reg_addr == pll_lock_pkg::OFS_IRQ_MASK) begin
				next_st.irq_mask = reg_wdata[pll_lock_pkg::EV_W-1:0];
			end
		end
		// Lock delay counter
		if (!qual) begin
			next_st.cnt = pll_lock_pkg::RST_CNT;
			next_st.lock = 1'b0;
		end else if (st.cnt < st.lock_count) begin
			next_st.cnt = cnt_inc;
			next_st.lock = cnt_inc >= st.lock_count;
		end else begin
			next_st.lock = 1'b1;
		end
		// Events
		if (st.ctrl[pll_lock_pkg::CTRL_MAIN_IRQ_EN]) begin
			ev_set[pll_lock_pkg::EV_MAIN_RISE] = next_st.lock & ~st.lock;
			ev_set[pll_lock_pkg::EV_MAIN_FALL] = ~next_st.lock & st.lock;
		end
		if (st.ctrl[pll_lock_pkg::CTRL_REF_MONITOR]) begin
			ev_set[pll_lock_pkg::EV_REF_RISE] = ref_rise;
			ev_set[pll_lock_pkg::EV_REF_FALL] = ref_fall;
		end
		// Set wins over clear
		next_st.irq_status = (st.irq_status & ~ev_clr) | ev_set;
		next_st.irq = |(next_st.irq_status & next_st.irq_mask);
		// Fabric copy of lock
		next_st.fabric_lock = next_st.ctrl[pll_lock_pkg::CTRL_FABRIC_OUT_EN] & next_st.lock;
		// Clock switch once both locks hold
		if (st.lock && ref_lock) begin
			next_st.clk_switch = 1'b1;
		end
		// Read data, valid the cycle after the strobe only
		if (reg_rd) begin
			next_st.rdata = read_mux(reg_addr, st, raw_lock, ref_lock, in_window);
		end else begin
			next_st.rdata = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			st.ctrl <= pll_lock_pkg::RST_CTRL;
			st.lock_count <= pll_lock_pkg::RST_LOCK_COUNT;
			st.lock_window <= pll_lock_pkg::RST_LOCK_WINDOW;
			st.irq_status <= pll_lock_pkg::RST_IRQ;
			st.irq_mask <= pll_lock_pkg::RST_IRQ;
			st.cnt <= pll_lock_pkg::RST_CNT;
			st.lock <= 1'b0;
			st.fabric_lock <= 1'b0;
			st.clk_switch <= 1'b0;
			st.irq <= 1'b0;
			st.rdata <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign reg_rdata = st.rdata;
	assign main_pll_lock = st.lock;
	assign main_pll_lock_fabric = st.fabric_lock;
	assign clk_cfg_switch = st.clk_switch;
	assign irq = st.irq;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	logic [pll_lock_pkg::CNT_W-1:0] run_len;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			run_len <= pll_lock_pkg::RST_CNT;
		end else if (!qual) begin
			run_len <= pll_lock_pkg::RST_CNT;
		end else if (run_len != 16'hffff) begin
			run_len <= run_len + 16'h0001;
		end
	end

	sequence s_main_rise;
		st.ctrl[pll_lock_pkg::CTRL_MAIN_IRQ_EN] && !st.lock ##1 st.lock;
	endsequence

	sequence s_main_fall;
		st.ctrl[pll_lock_pkg::CTRL_MAIN_IRQ_EN] && st.lock ##1 !st.lock;
	endsequence

	property p_lock_delay;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(st.lock) |-> (run_len == st.lock_count) || (st.lock_count == 16'h0000 && run_len == 16'h0001);
	endproperty
	a_lock_delay: assert property (p_lock_delay) else $error("lock rose after wrong delay");

	property p_lock_window;
		@(posedge sys_clk) disable iff (!resetn)
		st.lock |-> $past(in_window) && $past(raw_lock);
	endproperty
	a_lock_window: assert property (p_lock_window) else $error("lock held outside phase window");

	property p_main_irq;
		@(posedge sys_clk) disable iff (!resetn)
		(s_main_rise |-> st.irq_status[pll_lock_pkg::EV_MAIN_RISE])
		and (s_main_fall |-> st.irq_status[pll_lock_pkg::EV_MAIN_FALL]);
	endproperty
	a_main_irq: assert property (p_main_irq) else $error("main lock edge not flagged");

	property p_fabric_out;
		@(posedge sys_clk) disable iff (!resetn)
		main_pll_lock_fabric |-> st.lock && st.ctrl[pll_lock_pkg::CTRL_FABRIC_OUT_EN];
	endproperty
	a_fabric_out: assert property (p_fabric_out) else $error("fabric lock without lock or enable");

	property p_ref_irq;
		@(posedge sys_clk) disable iff (!resetn)
		(ref_rise || ref_fall) && st.ctrl[pll_lock_pkg::CTRL_REF_MONITOR]
		|=> st.irq_status[pll_lock_pkg::EV_REF_RISE] || st.irq_status[pll_lock_pkg::EV_REF_FALL];
	endproperty
	a_ref_irq: assert property (p_ref_irq) else $error("reference lock edge not flagged");

	property p_clk_switch;
		@(posedge sys_clk) disable iff (!resetn)
		$rose(clk_cfg_switch) |-> $past(st.lock) && $past(ref_lock);
	endproperty
	a_clk_switch: assert property (p_clk_switch) else $error("clock switch before both locks");

	property p_lock_drop;
		@(posedge sys_clk) disable iff (!resetn)
		!qual |=> !st.lock && st.cnt == 16'h0000 ##1 (!st.lock || $past(qual));
	endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("lock not cleared on raw drop");

	property p_lock_hold;
		@(posedge sys_clk) disable iff (!resetn)
		st.lock && qual && $stable(st.lock_count) |=> st.lock;
	endproperty
	a_lock_hold: assert property (p_lock_hold) else $error("lock lost while qualified");

	property p_lock_floor;
		@(posedge sys_clk) disable iff (!resetn)
		st.lock |-> run_len >= $past(st.lock_count);
	endproperty
	a_lock_floor: assert property (p_lock_floor) else $error("lock before delay count");

	property p_ref_rise_flag;
		@(posedge sys_clk) disable iff (!resetn)
		ref_rise && st.ctrl[pll_lock_pkg::CTRL_REF_MONITOR] |=> st.irq_status[pll_lock_pkg::EV_REF_RISE];
	endproperty
	a_ref_rise_flag: assert property (p_ref_rise_flag) else $error("reference rise not flagged");

	property p_ref_fall_flag;
		@(posedge sys_clk) disable iff (!resetn)
		ref_fall && st.ctrl[pll_lock_pkg::CTRL_REF_MONITOR] |=> st.irq_status[pll_lock_pkg::EV_REF_FALL];
	endproperty
	a_ref_fall_flag: assert property (p_ref_fall_flag) else $error("reference fall not flagged");

	property p_main_quiet;
		@(posedge sys_clk) disable iff (!resetn)
		!st.ctrl[pll_lock_pkg::CTRL_MAIN_IRQ_EN] && !st.irq_status[pll_lock_pkg::EV_MAIN_RISE]
		|=> !st.irq_status[pll_lock_pkg::EV_MAIN_RISE];
	endproperty
	a_main_quiet: assert property (p_main_quiet) else $error("main event flagged while disabled");

	property p_ref_quiet;
		@(posedge sys_clk) disable iff (!resetn)
		!st.ctrl[pll_lock_pkg::CTRL_REF_MONITOR] && !st.irq_status[pll_lock_pkg::EV_REF_RISE]
		|=> !st.irq_status[pll_lock_pkg::EV_REF_RISE];
	endproperty
	a_ref_quiet: assert property (p_ref_quiet) else $error("reference event flagged unmonitored");

	property p_irq_level;
		@(posedge sys_clk) disable iff (!resetn)
		irq == (|(st.irq_status & st.irq_mask));
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level disagrees with status");

	property p_switch_sticky;
		@(posedge sys_clk) disable iff (!resetn)
		clk_cfg_switch |=> clk_cfg_switch;
	endproperty
	a_switch_sticky: assert property (p_switch_sticky) else $error("clock switch withdrawn");

	property p_fabric_follow;
		@(posedge sys_clk) disable iff (!resetn)
		st.lock && st.ctrl[pll_lock_pkg::CTRL_FABRIC_OUT_EN] |-> main_pll_lock_fabric;
	endproperty
	a_fabric_follow: assert property (p_fabric_follow) else $error("fabric lock missing");

	sequence s_status_read;
		reg_rd && reg_addr == pll_lock_pkg::OFS_STATUS;
	endsequence

	property p_status_read;
		@(posedge sys_clk) disable iff (!resetn)
		s_status_read |=> reg_rdata[pll_lock_pkg::STAT_MAIN_LOCK] == $past(st.lock)
		&& reg_rdata[pll_lock_pkg::STAT_CLK_SWITCH] == $past(st.clk_switch);
	endproperty
	a_status_read: assert property (p_status_read) else $error("status read disagrees with state");

endmodule : pll_lock_qualifier

// ### test/pll_lock_model.sv
// Behavioural PLL lock source with a settle delay
`timescale 1ns/100ps

module pll_lock_model (
	// Clock
	input wire logic sys_clk,
	// Control and lock pin
	input wire logic want,
	input wire logic [7:0] settle,
	output logic lock
);
	logic [7:0] age;

	initial begin
		age = 8'h00;
		lock = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Lock rises once settled, drops at once
	always @(posedge sys_clk) begin
		age <= want ? age + ((age < settle) ? 8'h01 : 8'h00) : 8'h00;
		lock <= want && (age >= settle);
	end
endmodule : pll_lock_model

// ### test/tb_pll_lock_qualifier.sv
// Self-checking bench of the PLL lock qualifier
`timescale 1ns/100ps

module tb_pll_lock_qualifier;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic want_main = 1'b0;
	logic want_ref = 1'b0;
	logic raw_pin, ref_pin, lock, lock_fab, clk_sw, irq;
	logic [15:0] phase_err = 16'h0000;
	logic [31:0] seed = 32'heb5d;
	logic [31:0] rd;
	logic [2:0] ctrl;
	int errors = 0;
	int tests_run = 0;
	int n, c;

	pll_lock_qualifier u_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .main_pll_raw_lock(raw_pin),
		.main_pll_phase_err_ppm(phase_err), .fabric_ref_pll_lock_in(ref_pin), .main_pll_lock(lock),
		.main_pll_lock_fabric(lock_fab), .clk_cfg_switch(clk_sw), .irq(irq));
	pll_lock_model u_main_src (.sys_clk(sys_clk), .want(want_main), .settle(8'h02), .lock(raw_pin));
	pll_lock_model u_ref_src (.sys_clk(sys_clk), .want(want_ref), .settle(8'h03), .lock(ref_pin));

	////////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	function automatic logic [31:0] exp_main_ev(input logic [2:0] cfg, input logic fell);
		return cfg[0] ? {30'h0, fell, 1'b1} : 32'h0;
	endfunction : exp_main_ev

	task automatic finish_test();
		$display("errors=%0d tests_run=%0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rdreg(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdreg

	task automatic wait_for(input logic exp, input int lim);
		n = 0;
		while (lock !== exp && n < lim) begin
			@(posedge sys_clk);
			#1 n++;
		end
		if (lock !== exp) begin
			errors++;
			$display("MISMATCH lock wait expected %h seen %h", exp, lock);
			finish_test();
		end
	endtask : wait_for

	initial begin
		forever #12.5 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		logic [7:0] addrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h1c};
		logic [31:0] rsts [7] = '{32'h0, 32'h20, 32'h1f40, 32'h10, 32'h0, 32'h0, 32'h0};
		logic [2:0] cfgs [3] = '{3'h7, 3'h5, 3'h6};
		repeat (3) @(posedge sys_clk);
		resetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rdreg(addrs[i]);
			check("reset value", rsts[i], rd);
		end
		wr(8'h00, 32'h4);
		wr(8'h14, 32'hf);
		want_ref <= 1'b1;
		repeat (10) @(posedge sys_clk);
		rdreg(8'h10);
		check("ref rise event", 32'h4, rd);
		check("irq on ref rise", 1, irq);
		check("switch before main lock", 0, clk_sw);
		wr(8'h10, 32'h4);
		#1 check("irq after clear", 0, irq);
		c = 32;
		for (int i = 0; i < 3; i++) begin
			ctrl = cfgs[i];
			wr(8'h00, {29'h0, ctrl});
			if (i > 0) begin
				seed = xs(seed);
				c = 4 + int'(seed[3:0]);
				wr(8'h04, c);
			end
			phase_err <= 16'h1f41;
			want_main <= 1'b1;
			repeat (c + 10) @(posedge sys_clk);
			check("lock out of window", 0, lock);
			seed = xs(seed);
			phase_err <= (i == 0) ? 16'h1f40 : seed[15:0] % 16'h1f40;
			wait_for(1'b1, c + 10);
			check("lock delay in range", 1, (n >= c) && (n <= c + 2));
			check("fabric lock", ctrl[1], lock_fab);
			rdreg(8'h10);
			check("main rise event", exp_main_ev(ctrl, 1'b0), rd);
			check("clock switch", 1, clk_sw);
			want_main <= 1'b0;
			wait_for(1'b0, 6);
			check("lock drop", 1, n <= 4);
			check("fabric after drop", 0, lock_fab);
			rdreg(8'h10);
			check("main fall event", exp_main_ev(ctrl, 1'b1), rd);
			check("irq level", ctrl[0], irq);
			wr(8'h10, 32'h3);
		end
		want_main <= 1'b1;
		repeat (c / 2 + 3) @(posedge sys_clk);
		want_main <= 1'b0;
		repeat (6) @(posedge sys_clk);
		want_main <= 1'b1;
		wait_for(1'b1, c + 10);
		check("count restarts", c + 5, n);
		want_ref <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rdreg(8'h10);
		check("ref fall event", 32'h8, rd);
		wr(8'h14, 32'h0);
		#1 check("irq masked", 0, irq);
		finish_test();
	end
endmodule : tb_pll_lock_qualifier
